// *** logic/pca_pkg.sv ***
// What this block does
// - sixteen-bit counter read as two bytes
// - low read snapshots high byte for high read
// - counter reads never disturb counting
// - three-bit select picks one of eight timebases
// - oscillator over eight synchronised before counting
// - wrap from all ones sets overflow flag
// - overflow interrupt only when its enable set
// - flags never auto-cleared, software clears them
// - idle control clear keeps array running
// - intermediate overflow from bit 8 to 11
// - flags set regardless of interrupt enables
// - irq is OR of gated flags
// - six independent sixteen-bit channels with pins
// - mode bits 5 and 4 select capture edges
// - mode bits 3:1 select compare modes
// - bit 1 pwm, bit 7 sixteen-bit pwm
// - one shared cycle length for pwm
// - comparator off stops toggles, pwm low
// - reload select steers compare byte writes in n-bit pwm only
// - match flag enable makes matches set flag
// - pwm control bit 5 enables intermediate irq
// - capture edge loads count and sets flag
// - low write clears, high write sets comparator
package pca_pkg;
    localparam int PCA_CH = 6;
    localparam logic [3:0] PCA_DIV12 = 4'hB;
    localparam logic [1:0] PCA_DIV4 = 2'h3;
    localparam logic [2:0] PCA_TB_DIV12 = 3'h0;
    localparam logic [2:0] PCA_TB_DIV4 = 3'h1;
    localparam logic [2:0] PCA_TB_T0 = 3'h2;
    localparam logic [2:0] PCA_TB_ECI = 3'h3;
    localparam logic [2:0] PCA_TB_SYS = 3'h4;
    localparam logic [2:0] PCA_TB_XOSC = 3'h5;
    localparam logic [2:0] PCA_TB_T4 = 3'h6;
    localparam logic [2:0] PCA_TB_T5 = 3'h7;
    // channel mode register bit positions
    localparam int PCA_M_IE = 0;
    localparam int PCA_M_PWM = 1;
    localparam int PCA_M_TOG = 2;
    localparam int PCA_M_MAT = 3;
    localparam int PCA_M_CAPN = 4;
    localparam int PCA_M_CAPP = 5;
    localparam int PCA_M_ECOM = 6;
    localparam int PCA_M_PWM16 = 7;
    localparam logic [2:0] PCA_MD_SWT = 3'h4;
    localparam logic [2:0] PCA_MD_HSO = 3'h6;
    localparam logic [2:0] PCA_MD_FREQ = 3'h3;
    localparam logic [15:0] PCA_ONES = 16'hFFFF;
    localparam logic [15:0] PCA_ZERO16 = 16'h0000;
    localparam logic [7:0] PCA_ZERO8 = 8'h00;
    typedef enum logic [1:0] {
        PCA_CH_IDLE = 2'b00,
        PCA_CH_CAPT = 2'b01,
        PCA_CH_CMP = 2'b10,
        PCA_CH_PWM = 2'b11
    } pca_chkind_t;
endpackage

// *** logic/pca_channel.sv ***
`timescale 1ns/1ps
module pca_channel
    import pca_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic [15:0] count,
    input wire logic [15:0] count_next,
    input wire logic [7:0] mode,
    input wire logic [1:0] cyc_len,
    input wire logic [3:0] nbit_ovf,
    input wire logic pin_in,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic reload_sel,
    input wire logic [7:0] wr_data,
    input wire logic flag_clear,
    output logic [15:0] cap_q,
    output logic [15:0] reload_q,
    output logic ecom_q,
    output logic flag_q,
    output logic pin_out_q
);
    logic [1:0] pin_hist_q;
    logic rise;
    logic fall;
    logic capture;
    logic match;
    logic pwm8;
    logic pwmn;
    logic pwm16;
    logic [15:0] nmask;
    logic nbit_wrap;
    logic [2:0] sel;
    pca_chkind_t kind;

    assign sel = mode[PCA_M_MAT:PCA_M_PWM];
    always_comb begin
        if (sel == 3'h0) begin
            kind = (mode[PCA_M_CAPP] | mode[PCA_M_CAPN]) ? PCA_CH_CAPT
                                                          : PCA_CH_IDLE;
        end else if (mode[PCA_M_PWM] && !mode[PCA_M_TOG]) begin
            kind = PCA_CH_PWM;
        end else begin
            kind = PCA_CH_CMP;
        end
    end

    // two-stage history needs a level held only one clock to see an edge
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_hist_q <= 2'b00;
        end else begin
            pin_hist_q <= {pin_hist_q[0], pin_in};
        end
    end
    assign rise = pin_hist_q[0] & ~pin_hist_q[1];
    assign fall = ~pin_hist_q[0] & pin_hist_q[1];
    assign capture = (kind == PCA_CH_CAPT) &&
        ((rise && mode[PCA_M_CAPP]) || (fall && mode[PCA_M_CAPN]));

    assign pwm16 = (kind == PCA_CH_PWM) && mode[PCA_M_PWM16];
    assign pwm8 = (kind == PCA_CH_PWM) && !mode[PCA_M_PWM16] &&
        (cyc_len == 2'b00);
    assign pwmn = (kind == PCA_CH_PWM) && !mode[PCA_M_PWM16] &&
        (cyc_len != 2'b00);
    assign nmask = {4'h0, nbit_ovf, 8'hFF};
    assign nbit_wrap = tick && ((count_next & nmask) == PCA_ZERO16);

    always_comb begin
        if (kind == PCA_CH_CAPT || kind == PCA_CH_IDLE) begin
            match = 1'b0;
        end else if (sel == PCA_MD_FREQ) begin
            match = count[7:0] == cap_q[7:0];
        end else if (pwm8) begin
            match = count[7:0] == cap_q[7:0];
        end else if (pwmn) begin
            match = (count & nmask) == (cap_q & nmask);
        end else begin
            match = count == cap_q;
        end
        match = match && ecom_q && tick;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ecom_q <= 1'b0;
        end else if (wr_low) begin
            ecom_q <= 1'b0;
        end else if (wr_high) begin
            ecom_q <= 1'b1;
        end else begin
            ecom_q <= ecom_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cap_q <= PCA_ZERO16;
            reload_q <= PCA_ZERO16;
        end else begin
            if (wr_low && reload_sel && pwmn) begin
                reload_q[7:0] <= wr_data;
            end else if (wr_high && reload_sel && pwmn) begin
                reload_q[15:8] <= wr_data;
            end
            if (wr_low && !(reload_sel && pwmn)) begin
                cap_q[7:0] <= wr_data;
            end else if (wr_high && !(reload_sel && pwmn)) begin
                cap_q[15:8] <= wr_data;
            end else if (capture) begin
                cap_q <= count;
            end else if (match && sel == PCA_MD_FREQ) begin
                cap_q[7:0] <= cap_q[7:0] + cap_q[15:8];
            end else if (pwm8 && tick && count_next[7:0] == PCA_ZERO8) begin
                cap_q[7:0] <= cap_q[15:8];
            end else if (pwmn && nbit_wrap) begin
                cap_q <= reload_q;
            end
        end
    end

    // set beats a same-cycle software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (capture || (match && mode[PCA_M_MAT])) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out_q <= 1'b0;
        end else if (kind == PCA_CH_PWM) begin
            if (!ecom_q) begin
                pin_out_q <= 1'b0;
            end else if (pwm16 && tick && count_next == PCA_ZERO16) begin
                pin_out_q <= 1'b0;
            end else if (pwm8 && tick && count_next[7:0] == PCA_ZERO8) begin
                pin_out_q <= 1'b0;
            end else if (pwmn && nbit_wrap) begin
                pin_out_q <= 1'b0;
            end else if (match) begin
                pin_out_q <= 1'b1;
            end
        end else if (kind == PCA_CH_CMP && mode[PCA_M_TOG] && match) begin
            pin_out_q <= ~pin_out_q;
        end
    end
endmodule // pca_channel

// *** logic/pca_top.sv ***
`timescale 1ns/1ps
module pca_top
    import pca_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [2:0] TIMEBASE_SELECT,
    input wire logic COUNTER_RUN,
    input wire logic IDLE_HALT_CONTROL,
    input wire logic CPU_IDLE,
    input wire logic COUNTER_OVERFLOW_IRQ_ENABLE,
    input wire logic INTERMEDIATE_OVERFLOW_IRQ_ENABLE,
    input wire logic [1:0] CYCLE_LENGTH_SELECT,
    input wire logic RELOAD_ACCESS_SELECT,
    input wire logic TIMER0_OVERFLOW,
    input wire logic TIMER4_OVERFLOW,
    input wire logic TIMER5_OVERFLOW,
    input wire logic EXT_OSC_DIV8,
    input wire logic EXTERNAL_COUNT_INPUT,
    input wire logic COUNT_LOW_WRITE,
    input wire logic COUNT_HIGH_WRITE,
    input wire logic COUNT_LOW_READ,
    input wire logic [7:0] WRITE_DATA,
    input wire logic COUNTER_OVERFLOW_CLEAR,
    input wire logic INTERMEDIATE_OVERFLOW_CLEAR,
    input wire logic [47:0] CHANNEL_MODE_REGISTER,
    input wire logic [5:0] COMPARE_LOW_WRITE,
    input wire logic [5:0] COMPARE_HIGH_WRITE,
    input wire logic [5:0] CHANNEL_FLAG_CLEAR,
    input wire logic [5:0] CHANNEL_PIN_IN,
    output logic [7:0] COUNT_LOW_BYTE,
    output logic [7:0] COUNT_HIGH_BYTE,
    output logic COUNTER_OVERFLOW_FLAG,
    output logic INTERMEDIATE_OVERFLOW_FLAG,
    output logic [5:0] CHANNEL_EVENT_FLAG,
    output logic [5:0] COMPARATOR_ENABLE,
    output logic [95:0] COMPARE_VALUE,
    output logic [95:0] RELOAD_VALUE,
    output logic [5:0] CHANNEL_PIN,
    output logic ARRAY_IRQ
);
    logic [15:0] count_q;
    logic [15:0] count_next;
    logic [7:0] snap_q;
    logic [3:0] div12_q;
    logic [1:0] div4_q;
    logic [2:0] eci_q;
    logic [2:0] xosc_q;
    logic src_tick;
    logic tick;
    logic adv;
    logic [3:0] nbit_ovf;
    logic [5:0] flags;
    logic irq_d;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            div12_q <= 4'h0;
            div4_q <= 2'h0;
        end else begin
            div12_q <= (div12_q == PCA_DIV12) ? 4'h0 : div12_q + 4'h1;
            div4_q <= div4_q + 2'h1;
        end
    end

    // first stage of each chain feeds only the next stage
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            eci_q <= 3'h0;
            xosc_q <= 3'h0;
        end else begin
            eci_q <= {eci_q[1:0], EXTERNAL_COUNT_INPUT};
            xosc_q <= {xosc_q[1:0], EXT_OSC_DIV8};
        end
    end

    always_comb begin
        case (TIMEBASE_SELECT)
            PCA_TB_DIV12: src_tick = div12_q == PCA_DIV12;
            PCA_TB_DIV4: src_tick = div4_q == PCA_DIV4;
            PCA_TB_T0: src_tick = TIMER0_OVERFLOW;
            // edges faster than clock/2 may be missed
            PCA_TB_ECI: src_tick = eci_q[2] & ~eci_q[1];
            PCA_TB_SYS: src_tick = 1'b1;
            PCA_TB_XOSC: src_tick = xosc_q[1] & ~xosc_q[2];
            PCA_TB_T4: src_tick = TIMER4_OVERFLOW;
            PCA_TB_T5: src_tick = TIMER5_OVERFLOW;
            default: src_tick = 1'b0;
        endcase
    end
    assign tick = src_tick && COUNTER_RUN &&
        !(IDLE_HALT_CONTROL && CPU_IDLE);
    assign count_next = count_q + 16'h0001;
    // a count write pre-empts the step, so no wrap or match on it
    assign adv = tick && !COUNT_LOW_WRITE && !COUNT_HIGH_WRITE;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            count_q <= PCA_ZERO16;
        end else if (COUNT_LOW_WRITE) begin
            count_q[7:0] <= WRITE_DATA;
        end else if (COUNT_HIGH_WRITE) begin
            count_q[15:8] <= WRITE_DATA;
        end else if (tick) begin
            count_q <= count_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            snap_q <= PCA_ZERO8;
        end else if (COUNT_LOW_READ) begin
            snap_q <= count_q[15:8];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            COUNT_LOW_BYTE <= PCA_ZERO8;
            COUNT_HIGH_BYTE <= PCA_ZERO8;
        end else begin
            COUNT_LOW_BYTE <= count_q[7:0];
            COUNT_HIGH_BYTE <= COUNT_LOW_READ ? count_q[15:8] : snap_q;
        end
    end

    always_comb begin
        case (CYCLE_LENGTH_SELECT)
            2'b00: nbit_ovf = 4'h0;
            2'b01: nbit_ovf = 4'h1;
            2'b10: nbit_ovf = 4'h3;
            2'b11: nbit_ovf = 4'h7;
            default: nbit_ovf = 4'h0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            COUNTER_OVERFLOW_FLAG <= 1'b0;
        end else if (adv && count_q == PCA_ONES) begin
            COUNTER_OVERFLOW_FLAG <= 1'b1;
        end else if (COUNTER_OVERFLOW_CLEAR) begin
            COUNTER_OVERFLOW_FLAG <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            INTERMEDIATE_OVERFLOW_FLAG <= 1'b0;
        end else if (adv && (count_next & {4'h0, nbit_ovf, 8'hFF})
                     == PCA_ZERO16) begin
            INTERMEDIATE_OVERFLOW_FLAG <= 1'b1;
        end else if (INTERMEDIATE_OVERFLOW_CLEAR) begin
            INTERMEDIATE_OVERFLOW_FLAG <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PCA_CH; g++) begin : g_ch
            pca_channel u_ch (
                .clk(CLOCK),
                .srst(SRST),
                .tick(adv),
                .count(count_q),
                .count_next(count_next),
                .mode(CHANNEL_MODE_REGISTER[g*8 +: 8]),
                .cyc_len(CYCLE_LENGTH_SELECT),
                .nbit_ovf(nbit_ovf),
                .pin_in(CHANNEL_PIN_IN[g]),
                .wr_low(COMPARE_LOW_WRITE[g]),
                .wr_high(COMPARE_HIGH_WRITE[g]),
                .reload_sel(RELOAD_ACCESS_SELECT),
                .wr_data(WRITE_DATA),
                .flag_clear(CHANNEL_FLAG_CLEAR[g]),
                .cap_q(COMPARE_VALUE[g*16 +: 16]),
                .reload_q(RELOAD_VALUE[g*16 +: 16]),
                .ecom_q(COMPARATOR_ENABLE[g]),
                .flag_q(CHANNEL_EVENT_FLAG[g]),
                .pin_out_q(CHANNEL_PIN[g])
            );
            assign flags[g] = CHANNEL_EVENT_FLAG[g] &
                CHANNEL_MODE_REGISTER[g*8 + PCA_M_IE];
        end
    endgenerate

    assign irq_d = (COUNTER_OVERFLOW_FLAG && COUNTER_OVERFLOW_IRQ_ENABLE)
        || (INTERMEDIATE_OVERFLOW_FLAG
            && INTERMEDIATE_OVERFLOW_IRQ_ENABLE)
        || (|flags);

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ARRAY_IRQ <= 1'b0;
        end else begin
            ARRAY_IRQ <= irq_d;
        end
    end
endmodule // pca_top

// *** test/pca_monitor.sv ***
`timescale 1ns/1ps
module pca_monitor
    import pca_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [2:0] TIMEBASE_SELECT,
    input wire logic COUNTER_RUN,
    input wire logic IDLE_HALT_CONTROL,
    input wire logic CPU_IDLE,
    input wire logic COUNTER_OVERFLOW_IRQ_ENABLE,
    input wire logic INTERMEDIATE_OVERFLOW_IRQ_ENABLE,
    input wire logic COUNT_LOW_WRITE,
    input wire logic COUNT_HIGH_WRITE,
    input wire logic COUNT_LOW_READ,
    input wire logic [47:0] CHANNEL_MODE_REGISTER,
    input wire logic [5:0] COMPARE_LOW_WRITE,
    input wire logic [5:0] COMPARE_HIGH_WRITE,
    input wire logic [5:0] CHANNEL_FLAG_CLEAR,
    input wire logic [7:0] COUNT_LOW_BYTE,
    input wire logic [7:0] COUNT_HIGH_BYTE,
    input wire logic COUNTER_OVERFLOW_FLAG,
    input wire logic INTERMEDIATE_OVERFLOW_FLAG,
    input wire logic [5:0] CHANNEL_EVENT_FLAG,
    input wire logic [5:0] COMPARATOR_ENABLE,
    input wire logic [5:0] CHANNEL_PIN,
    input wire logic ARRAY_IRQ
);
    logic [5:0] ien;
    logic [5:0] pwm_off;
    logic irq_src;
    always_comb begin
        for (int i = 0; i < PCA_CH; i++) begin
            ien[i] = CHANNEL_MODE_REGISTER[8*i+PCA_M_IE];
            pwm_off[i] = CHANNEL_MODE_REGISTER[8*i+PCA_M_PWM]
                & !CHANNEL_MODE_REGISTER[8*i+PCA_M_TOG] & !COMPARATOR_ENABLE[i];
        end
    end
    assign irq_src = (COUNTER_OVERFLOW_FLAG & COUNTER_OVERFLOW_IRQ_ENABLE)
        | (INTERMEDIATE_OVERFLOW_FLAG & INTERMEDIATE_OVERFLOW_IRQ_ENABLE)
        | (|(CHANNEL_EVENT_FLAG & ien));
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // a one-edge reset still leaves stale history behind
    sequence fresh;
        !$past(SRST);
    endsequence
    // reads are left out on purpose: they must not slow the count
    sequence run_sys;
        TIMEBASE_SELECT == PCA_TB_SYS && COUNTER_RUN
            && !(IDLE_HALT_CONTROL && CPU_IDLE)
            && !COUNT_LOW_WRITE && !COUNT_HIGH_WRITE;
    endsequence
    irq_gating_a: assert property (fresh |-> ARRAY_IRQ == $past(irq_src))
        else $error("irq does not follow gated flags");
    chan_hold_a: assert property (fresh |-> (~CHANNEL_EVENT_FLAG
        & $past(CHANNEL_EVENT_FLAG) & ~$past(CHANNEL_FLAG_CLEAR)) == 6'h00)
        else $error("channel flag dropped without clear");
    low_write_a: assert property (fresh |->
        (COMPARATOR_ENABLE & $past(COMPARE_LOW_WRITE)) == 6'h00)
        else $error("low write left comparator on");
    high_write_a: assert property (fresh |-> (~COMPARATOR_ENABLE
        & $past(COMPARE_HIGH_WRITE) & ~$past(COMPARE_LOW_WRITE)) == 6'h00)
        else $error("high write left comparator off");
    ecom_hold_a: assert property (fresh |-> ((COMPARATOR_ENABLE
        ^ $past(COMPARATOR_ENABLE)) & ~$past(COMPARE_LOW_WRITE)
        & ~$past(COMPARE_HIGH_WRITE)) == 6'h00)
        else $error("comparator enable moved without write");
    pwm_off_a: assert property (fresh |->
        ($past(pwm_off) & pwm_off & CHANNEL_PIN) == 6'h00)
        else $error("pwm pin high with comparator off");
    snapshot_a: assert property (fresh ##0 !$past(COUNT_LOW_READ) |->
        $stable(COUNT_HIGH_BYTE))
        else $error("high byte moved without low read");
    sys_count_a: assert property (run_sys [*3] |=>
        COUNT_LOW_BYTE == $past(COUNT_LOW_BYTE) + 8'h01)
        else $error("counter missed a system clock tick");
endmodule // pca_monitor

bind pca_top pca_monitor mon (.CLOCK(CLOCK), .SRST(SRST),
    .TIMEBASE_SELECT(TIMEBASE_SELECT), .COUNTER_RUN(COUNTER_RUN),
    .IDLE_HALT_CONTROL(IDLE_HALT_CONTROL), .CPU_IDLE(CPU_IDLE),
    .COUNTER_OVERFLOW_IRQ_ENABLE(COUNTER_OVERFLOW_IRQ_ENABLE),
    .INTERMEDIATE_OVERFLOW_IRQ_ENABLE(INTERMEDIATE_OVERFLOW_IRQ_ENABLE),
    .COUNT_LOW_WRITE(COUNT_LOW_WRITE), .COUNT_HIGH_WRITE(COUNT_HIGH_WRITE),
    .COUNT_LOW_READ(COUNT_LOW_READ),
    .CHANNEL_MODE_REGISTER(CHANNEL_MODE_REGISTER),
    .COMPARE_LOW_WRITE(COMPARE_LOW_WRITE),
    .COMPARE_HIGH_WRITE(COMPARE_HIGH_WRITE),
    .CHANNEL_FLAG_CLEAR(CHANNEL_FLAG_CLEAR),
    .COUNT_LOW_BYTE(COUNT_LOW_BYTE), .COUNT_HIGH_BYTE(COUNT_HIGH_BYTE),
    .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG),
    .INTERMEDIATE_OVERFLOW_FLAG(INTERMEDIATE_OVERFLOW_FLAG),
    .CHANNEL_EVENT_FLAG(CHANNEL_EVENT_FLAG),
    .COMPARATOR_ENABLE(COMPARATOR_ENABLE), .CHANNEL_PIN(CHANNEL_PIN),
    .ARRAY_IRQ(ARRAY_IRQ));

// *** test/pca_pin_model.sv ***
`timescale 1ns/1ps
module pca_pin_model (
    input wire logic clk,
    output logic [5:0] pins,
    output logic eci
);
    initial begin
        pins = 6'h00;
        eci = 1'b1;
    end
    // three clocks per level, two more than the minimum
    task automatic set_pins(input logic [5:0] v);
        @(posedge clk) #1 pins = v;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // low held two clocks and high three, so falls never exceed clock over four
    task automatic eci_falls(input int n);
        repeat (n) begin
            @(posedge clk) #1 eci = 1'b0;
            repeat (2) @(posedge clk);
            #1 eci = 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule // pca_pin_model

// *** test/tb_programmable_counter_array.sv ***
`timescale 1ns/1ps
module tb_programmable_counter_array;
    import pca_pkg::*;
    typedef struct {
        string name;
        int idx;
        logic [15:0] exp;
        bit tol;
    } pca_note_t;
    logic clk, srst, run, halt, idle, cfie, iofie, rsel, tmr, xosc, eci;
    logic wlo, whi, rlo, cfclr, ioclr, cf, iof, irq;
    logic [1:0] cyc;
    logic [2:0] tbsel;
    logic [7:0] wdata, lo, hi;
    logic [47:0] mode;
    logic [5:0] cwlo, cwhi, fclr, pins, cef, ecom, cpin;
    logic [95:0] cval, rval;
    pca_note_t notes[$];
    event seen;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    pca_top dut (.CLOCK(clk), .SRST(srst), .TIMEBASE_SELECT(tbsel),
        .COUNTER_RUN(run), .IDLE_HALT_CONTROL(halt), .CPU_IDLE(idle),
        .COUNTER_OVERFLOW_IRQ_ENABLE(cfie),
        .INTERMEDIATE_OVERFLOW_IRQ_ENABLE(iofie), .CYCLE_LENGTH_SELECT(cyc),
        .RELOAD_ACCESS_SELECT(rsel), .TIMER0_OVERFLOW(tmr),
        .TIMER4_OVERFLOW(tmr), .TIMER5_OVERFLOW(tmr), .EXT_OSC_DIV8(xosc),
        .EXTERNAL_COUNT_INPUT(eci), .COUNT_LOW_WRITE(wlo),
        .COUNT_HIGH_WRITE(whi), .COUNT_LOW_READ(rlo), .WRITE_DATA(wdata),
        .COUNTER_OVERFLOW_CLEAR(cfclr), .INTERMEDIATE_OVERFLOW_CLEAR(ioclr),
        .CHANNEL_MODE_REGISTER(mode), .COMPARE_LOW_WRITE(cwlo),
        .COMPARE_HIGH_WRITE(cwhi), .CHANNEL_FLAG_CLEAR(fclr),
        .CHANNEL_PIN_IN(pins), .COUNT_LOW_BYTE(lo), .COUNT_HIGH_BYTE(hi),
        .COUNTER_OVERFLOW_FLAG(cf), .INTERMEDIATE_OVERFLOW_FLAG(iof),
        .CHANNEL_EVENT_FLAG(cef), .COMPARATOR_ENABLE(ecom),
        .COMPARE_VALUE(cval), .RELOAD_VALUE(rval), .CHANNEL_PIN(cpin),
        .ARRAY_IRQ(irq));
    pca_pin_model pm (.clk(clk), .pins(pins), .eci(eci));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic note(input string s, input int i, input logic [15:0] e,
        input bit t = 1'b0);
        notes.push_back('{s, i, e, t});
        -> seen;
    endtask
    function automatic logic [15:0] got(input string s, input int i);
        case (s)
            "count": return {hi, lo};
            "cap": return cval[16*i +: 16];
            "reload": return rval[16*i +: 16];
            "flags": return 16'({cf, iof, cef});
            "ecom": return 16'(ecom);
            "pin": return 16'(cpin);
            default: return 16'(irq);
        endcase
    endfunction
    // divided timebases start at an unknown prescaler phase
    task automatic cmp(input string s, input logic [15:0] e, g, input bit t);
        compares++;
        if (!(g === e || (t && (g + 16'h0001 === e || g - 16'h0001 === e)))) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    initial forever begin
        @(seen);
        while (notes.size() > 0) begin
            pca_note_t n;
            n = notes.pop_front();
            cmp(n.name, n.exp, got(n.name, n.idx), n.tol);
        end
    end
    task automatic wr16(input bit c, input int ch, input logic [15:0] v);
        wdata = v[7:0];
        wlo = !c;
        cwlo = 6'(c) << ch;
        step(1);
        wdata = v[15:8];
        {wlo, whi} = {1'b0, !c};
        cwlo = 6'h00;
        cwhi = 6'(c) << ch;
        step(1);
        whi = 1'b0;
        cwhi = 6'h00;
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            {tmr, xosc} = 2'b11;
            step(1);
            tmr = 1'b0;
            step(3);
            xosc = 1'b0;
            step(4);
        end
    endtask
    task automatic count_is(input logic [15:0] e, input bit t);
        rlo = 1'b1;
        step(1);
        rlo = 1'b0;
        step(2);
        note("count", 0, e, t);
    endtask
    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        int k;
        int n;
        logic [15:0] a;
        logic [15:0] b;
        void'($urandom(57));
        {srst, run, halt, idle, cfie, iofie, rsel, tmr, xosc} = 9'h120;
        {wlo, whi, rlo, cfclr, ioclr, cyc, tbsel, wdata} = 18'h00000;
        {mode, cwlo, cwhi, fclr} = 66'h0;
        step(12);
        srst = 1'b0;
        step(2);
        note("count", 0, 16'h0000);
        note("flags", 0, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            k = 3 + $urandom % 8;
            n = 8 * k + 6;
            tbsel = 3'(i);
            halt = (i == 8);
            wr16(1'b0, 0, 16'h0000);
            run = 1'b1;
            fork
                pulses(k);
                pm.eci_falls(k);
            join
            step(6);
            run = 1'b0;
            count_is(16'(i == 0 ? n / 12 : i == 1 ? n / 4 : i == 4 ? n
                : i == 8 ? 0 : k), i < 2);
        end
        halt = 1'b0;
        tbsel = PCA_TB_SYS;
        for (int c = 0; c < 5; c++) begin
            {cyc, cfie, iofie} = {2'(c), c == 4, c == 1};
            wr16(1'b0, 0, c < 4 ? (16'h0100 << c) - 16'h0002 : 16'hFFFE);
            // a low read mid-run must not disturb counting
            {run, rlo} = 2'b11;
            step(1);
            rlo = 1'b0;
            step(3);
            run = 1'b0;
            step(2);
            note("flags", 0, c < 4 ? 16'h0040 : 16'h00C0);
            note("irq", 0, 16'(c == 1 || c == 4));
            {cfclr, ioclr} = 2'b11;
            step(1);
            {cfclr, ioclr} = 2'b00;
            step(2);
            note("flags", 0, 16'h0000);
        end
        mode = {24'h000000, 8'h30, 8'h10, 8'h21};
        a = 16'($urandom);
        b = ~a;
        wr16(1'b0, 0, a);
        pm.set_pins(6'h07);
        wr16(1'b0, 0, b);
        pm.set_pins(6'h00);
        step(1);
        for (int ch = 0; ch < 3; ch++) begin
            note("cap", ch, ch == 0 ? a : b);
        end
        note("flags", 0, 16'h0007);
        note("irq", 0, 16'h0001);
        fclr = 6'h01;
        step(1);
        fclr = 6'h3E;
        step(2);
        note("flags", 0, 16'h0000);
        note("irq", 0, 16'h0000);
        fclr = 6'h00;
        mode = {8'h02, 8'h0C, 8'h08, 24'h000000};
        for (int ch = 3; ch < 6; ch++) begin
            wr16(1'b1, ch, 16'h0010 + 16'($urandom % 32));
        end
        cwlo = 6'h20;
        step(1);
        cwlo = 6'h00;
        step(2);
        note("ecom", 0, 16'h0018);
        wr16(1'b0, 0, 16'h0000);
        run = 1'b1;
        step(64);
        run = 1'b0;
        step(2);
        note("flags", 0, 16'h0018);
        note("pin", 0, 16'h0010);
        mode = {40'h0000000000, 8'h02};
        {cyc, rsel} = 3'b011;
        wr16(1'b1, 0, a);
        rsel = 1'b0;
        wr16(1'b1, 0, b);
        step(2);
        note("reload", 0, a);
        note("cap", 0, b);
        wr16(1'b0, 0, 16'h01FE);
        run = 1'b1;
        step(2);
        run = 1'b0;
        step(2);
        note("cap", 0, a);
        note("pin", 0, 16'h0010);
        step(2);
        final_report();
    end
endmodule // tb_programmable_counter_array
